// file: hw/timer_two_pkg.sv
/*
  shared constants and carrier types for the timer two control block:
  register offsets, bit positions, reset values and the apb carrier.
  assumes a 32-bit apb master and one 40 MHz clock.
*/
package timer_two_pkg;
  // byte offsets of the registers (one aligned word each)
  localparam logic [11:0] CTRL_OFFSET     = 12'h0c8;  // control register
  localparam logic [11:0] COUNT_OFFSET    = 12'h0cc;  // count high:low
  localparam logic [11:0] RELOAD_OFFSET   = 12'h0d0;  // reload high:low
  localparam logic [11:0] IRQ_STAT_OFFSET = 12'h0d4;  // sticky event status
  localparam logic [11:0] IRQ_EN_OFFSET   = 12'h0d8;  // event enables
  localparam logic [11:0] IRQ_CLR_OFFSET  = 12'h0dc;  // write one to clear
  localparam logic [11:0] MODE_OFFSET     = 12'h0e0;  // up/down mode bit
  // control register bit positions
  localparam int OVF_BIT   = 7;
  localparam int EXT_BIT   = 6;
  localparam int RXB_BIT   = 5;
  localparam int TXB_BIT   = 4;
  localparam int EXEN_BIT  = 3;
  localparam int RUN_BIT   = 2;
  localparam int CNT_BIT   = 1;
  localparam int CAP_BIT   = 0;
  // reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0]  IRQ_RESET   = 2'h0;
  // interrupt status layout: bit0 overflow, bit1 external event
  localparam int IRQ_OVF = 0;
  localparam int IRQ_EXT = 1;

  // apb request from master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // apb answer to master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // serial port clock selections
  typedef struct packed {
    logic rxUseTimer;
    logic txUseTimer;
    logic rxBaudTick;
    logic txBaudTick;
  } baud_t;
endpackage

// file: hw/timer_two_control.sv
/*
  timer two control: 16-bit timer/counter with capture and auto-reload,
  baud clock selection for the serial port, sticky event flags and an
  apb register slave. assumes pins already synchronous to ref_clk and
  the timer one overflow given as a one-cycle pulse.
*/
// Implementation choice: register access over APB.
// Notes on behaviour
// - enabled trigger fall captures or reloads, not in baud
// - trigger pin ignored while pin enable clear
// - trigger action sets sticky event flag
// - receive baud select picks timer or timer one
// - transmit baud select picks timer or timer one
// - counting only while run control set
// - counter select clear counts every clock
// - counter select set counts input falling edges
// - baud select forces auto-reload on overflow
// - control register resets to zero
// - baud, auto-reload and capture share reload pair
`timescale 1ns/10ps
`default_nettype none
module timer_two_control
  import timer_two_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire timer_two_pkg::apb_req_t apbReq,
  output var  timer_two_pkg::apb_rsp_t apbRsp,
  input  wire logic                    captureTriggerPin,
  input  wire logic                    countInputPin,
  input  wire logic                    timerOneOverflow,
  output var  timer_two_pkg::baud_t    baud,
  output logic                         irq
);
  import timer_two_pkg::*;

  // whole module state in one packed struct
  typedef struct packed {
    logic [7:0]  ctrl;       // control register
    logic [15:0] count;      // count high:low
    logic [15:0] reload;     // reload high:low
    logic [1:0]  irqEn;      // interrupt enables
    logic        upDown;     // up/down counter mode flag
    logic        trigPrev;   // last trigger pin level
    logic        cntPrev;    // last count pin level
    apb_rsp_t    rsp;        // registered apb answer
    baud_t       baud;       // registered baud outputs
    logic        irq;        // registered interrupt
  } state_t;

  state_t cur;        // registered state
  state_t next_cur;   // next state

  // decoded events of this cycle
  logic trigFall;     // falling edge on the trigger pin
  logic cntFall;      // falling edge on the count pin
  logic tick;         // timer advances this cycle
  logic overflow;     // count wraps this cycle
  logic baudMode;     // timer clocks the serial port
  logic trigAct;      // enabled trigger takes effect
  logic access;       // apb access phase
  logic [1:0] status; // sticky flags in status layout

  // combinational event decode
  always_comb
  begin
    trigFall = cur.trigPrev & ~captureTriggerPin;
    cntFall  = cur.cntPrev & ~countInputPin;
    baudMode = cur.ctrl[RXB_BIT] | cur.ctrl[TXB_BIT];
    tick = cur.ctrl[RUN_BIT] & (cur.ctrl[CNT_BIT] ? cntFall : 1'b1);
    overflow = tick & (cur.count == 16'hffff);
    trigAct = cur.ctrl[EXEN_BIT] & trigFall & ~baudMode;
    access = apbReq.psel & apbReq.penable;
    status = {cur.ctrl[EXT_BIT], cur.ctrl[OVF_BIT]};
  end

  // next state: counting, flags, apb
  always_comb
  begin
    next_cur = cur;
    next_cur.trigPrev = captureTriggerPin;
    next_cur.cntPrev  = countInputPin;
    // counter advance
    if (tick)
    begin
      next_cur.count = cur.count + 16'h0001;
    end
    // one reload pair for every use
    if (overflow && (baudMode || !cur.ctrl[CAP_BIT]))
    begin
      next_cur.count = cur.reload;
    end
    if (trigAct)
    begin
      if (cur.ctrl[CAP_BIT])
      begin
        next_cur.reload = cur.count;
      end
      else
      begin
        next_cur.count = cur.reload;
      end
    end
    // apb access: writes happen before hardware sets so set wins
    next_cur.rsp.pready  = 1'b0;
    next_cur.rsp.pslverr = 1'b0;
    next_cur.rsp.prdata  = 32'h0000_0000;
    if (apbReq.psel && !apbReq.penable)
    begin
      // answer prepared in the access phase below; one wait state
      next_cur.rsp.pready = 1'b0;
    end
    if (access && !cur.rsp.pready)
    begin
      next_cur.rsp.pready = 1'b1;
      unique case (apbReq.paddr)
        CTRL_OFFSET:
        begin
          next_cur.rsp.prdata = {24'h000000, cur.ctrl};
          if (apbReq.pwrite)
          begin
            next_cur.ctrl = apbReq.pwdata[7:0];
          end
        end
        COUNT_OFFSET:
        begin
          next_cur.rsp.prdata = {16'h0000, cur.count};
          if (apbReq.pwrite)
          begin
            next_cur.count = apbReq.pwdata[15:0];
          end
        end
        RELOAD_OFFSET:
        begin
          next_cur.rsp.prdata = {16'h0000, cur.reload};
          if (apbReq.pwrite)
          begin
            next_cur.reload = apbReq.pwdata[15:0];
          end
        end
        IRQ_STAT_OFFSET:
        begin
          next_cur.rsp.prdata = {30'h00000000, status};
        end
        IRQ_EN_OFFSET:
        begin
          next_cur.rsp.prdata = {30'h00000000, cur.irqEn};
          if (apbReq.pwrite)
          begin
            next_cur.irqEn = apbReq.pwdata[1:0];
          end
        end
        IRQ_CLR_OFFSET:
        begin
          // write-only: reads give zero
          if (apbReq.pwrite)
          begin
            next_cur.ctrl[OVF_BIT] = cur.ctrl[OVF_BIT] & ~apbReq.pwdata[IRQ_OVF];
            next_cur.ctrl[EXT_BIT] = cur.ctrl[EXT_BIT] & ~apbReq.pwdata[IRQ_EXT];
          end
        end
        MODE_OFFSET:
        begin
          next_cur.rsp.prdata = {31'h00000000, cur.upDown};
          if (apbReq.pwrite)
          begin
            next_cur.upDown = apbReq.pwdata[0];
          end
        end
        default:
        begin
          // unmapped: error answer
          next_cur.rsp.pslverr = 1'b1;
        end
      endcase
    end
    if (overflow && !baudMode)
    begin
      next_cur.ctrl[OVF_BIT] = 1'b1;
    end
    if (trigAct)
    begin
      next_cur.ctrl[EXT_BIT] = 1'b1;
    end
    next_cur.baud.rxUseTimer = next_cur.ctrl[RXB_BIT];
    next_cur.baud.txUseTimer = next_cur.ctrl[TXB_BIT];
    next_cur.baud.rxBaudTick = cur.ctrl[RXB_BIT] ? overflow : timerOneOverflow;
    next_cur.baud.txBaudTick = cur.ctrl[TXB_BIT] ? overflow : timerOneOverflow;
    // event flag never interrupts in up/down mode
    next_cur.irq = (next_cur.ctrl[OVF_BIT] & next_cur.irqEn[IRQ_OVF])
                 | (next_cur.ctrl[EXT_BIT] & next_cur.irqEn[IRQ_EXT]
                    & ~next_cur.upDown);
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cur          <= '0;
      cur.ctrl     <= CTRL_RESET;
      cur.count    <= COUNT_RESET;
      cur.reload   <= COUNT_RESET;
      cur.irqEn    <= IRQ_RESET;
      cur.trigPrev <= 1'b1;
      cur.cntPrev  <= 1'b1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // outputs straight from flip-flops
  assign apbRsp = cur.rsp;
  assign baud   = cur.baud;
  assign irq    = cur.irq;

  chk_run_stop_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !cur.ctrl[RUN_BIT] && !(access && apbReq.pwrite) && !trigAct |=> $stable(cur.count))
    else $error("count moved while stopped");
  chk_timer_inc: assert property (@(posedge ref_clk) disable iff (rst)
    cur.ctrl[RUN_BIT] && !cur.ctrl[CNT_BIT] && cur.count != 16'hffff && !trigAct
    && !access |=> cur.count == $past(cur.count) + 16'h0001)
    else $error("timer did not increment");
  // counter mode needs a pin fall
  chk_counter_edge: assert property (@(posedge ref_clk) disable iff (rst)
    cur.ctrl[CNT_BIT] && !cntFall && !trigAct && !access |=> $stable(cur.count))
    else $error("counter moved without edge");
  chk_trig_ignore: assert property (@(posedge ref_clk) disable iff (rst)
    !cur.ctrl[EXEN_BIT] && !cur.ctrl[EXT_BIT] && !access |=> !cur.ctrl[EXT_BIT])
    else $error("event flag set while pin disabled");
  chk_ext_set: assert property (@(posedge ref_clk) disable iff (rst)
    trigAct |=> cur.ctrl[EXT_BIT])
    else $error("event flag not set");
  // no trigger action in baud mode
  chk_baud_no_trig: assert property (@(posedge ref_clk) disable iff (rst)
    baudMode |-> !trigAct)
    else $error("trigger acted in baud mode");
  chk_baud_reload: assert property (@(posedge ref_clk) disable iff (rst)
    overflow && baudMode && !access |=> cur.count == $past(cur.reload))
    else $error("no forced reload");
  chk_ovf_flag: assert property (@(posedge ref_clk) disable iff (rst)
    overflow && !baudMode |=> cur.ctrl[OVF_BIT])
    else $error("overflow flag missing");
  chk_rx_source: assert property (@(posedge ref_clk) disable iff (rst)
    cur.ctrl[RXB_BIT] && overflow |=> baud.rxBaudTick)
    else $error("receive tick missing");
  chk_tx_source: assert property (@(posedge ref_clk) disable iff (rst)
    !cur.ctrl[TXB_BIT] |=> baud.txBaudTick == $past(timerOneOverflow))
    else $error("transmit tick wrong source");
  chk_capture: assert property (@(posedge ref_clk) disable iff (rst)
    trigAct && cur.ctrl[CAP_BIT] && !access |=> cur.reload == $past(cur.count))
    else $error("capture lost");
  chk_reset_ctrl: assert property (@(posedge ref_clk)
    rst |=> cur.ctrl == CTRL_RESET)
    else $error("control not cleared");

  cov_overflow: cover property (@(posedge ref_clk) disable iff (rst) overflow);
  cov_capture:  cover property (@(posedge ref_clk) disable iff (rst)
    trigAct && cur.ctrl[CAP_BIT]);
  cov_baud:     cover property (@(posedge ref_clk) disable iff (rst) overflow && baudMode);
  cov_irq:      cover property (@(posedge ref_clk) disable iff (rst) irq);
endmodule
`default_nettype wire

// file: dv/test_timer_two_control.sv
/*
  self-checking bench for timer two control: register access over apb,
  timer and counter modes, capture and reload, flags, interrupt, baud ticks.
  assumes a one-wait-state apb slave and pins synchronous to ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module test_timer_two_control;
  import timer_two_pkg::*;
  // one table row: write first when w is set, then read back
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} row_t;
  logic     ref_clk   = 1'b0;  // 40 MHz clock
  logic     rst       = 1'b1;  // synchronous reset
  apb_req_t apbReq    = '0;    // master request
  apb_rsp_t apbRsp;            // slave answer
  logic     trigPin   = 1'b1;  // idles high so only driven falls count
  logic     cntPin    = 1'b1;  // count input, idle high
  logic     tOneOvf   = 1'b0;  // timer one overflow pulse
  baud_t    baud;              // serial clock outputs
  logic     irq;               // level interrupt
  int       err_count = 0;     // mismatches
  int       cmp_count = 0;     // comparisons
  logic [31:0] r0, r1;         // read scratch
  logic        e0;             // error scratch
  int          hits;           // tick count
  row_t rows [14] = '{
    '{0, CTRL_OFFSET, 0, 0, 0}, '{0, COUNT_OFFSET, 0, 0, 0}, '{0, RELOAD_OFFSET, 0, 0, 0},
    '{0, IRQ_STAT_OFFSET, 0, 0, 0}, '{0, IRQ_EN_OFFSET, 0, 0, 0}, '{0, MODE_OFFSET, 0, 0, 0},
    '{1, COUNT_OFFSET, 32'h0000abcd, 32'h0000abcd, 0},
    '{1, RELOAD_OFFSET, 32'h12345678, 32'h00005678, 0},
    '{1, IRQ_EN_OFFSET, 32'h3, 32'h3, 0}, '{1, IRQ_CLR_OFFSET, 32'h3, 32'h0, 0},
    '{1, IRQ_STAT_OFFSET, 32'h3, 32'h0, 0}, '{1, CTRL_OFFSET, 32'h0b, 32'h0b, 0},
    '{1, CTRL_OFFSET, 32'h0, 32'h0, 0}, '{1, 12'h0fc, 32'h1, 32'h0, 1}};

  always #12.5 ref_clk = ~ref_clk;

  timer_two_control i_dut (.ref_clk(ref_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .captureTriggerPin(trigPin), .countInputPin(cntPin), .timerOneOverflow(tOneOvf),
    .baud(baud), .irq(irq));

  // verdict and end of run, the one place that stops simulation
  task automatic end_of_test;
    $display("counts: %0d compared, %0d unexpected", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (apbRsp.pready !== 1'b1 && n < 20);
    r = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq <= '0;
    // a slave that never answers ends the run
    if (n >= 20)
    begin
      err_count++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
  endtask

  // bounded wait for irq (0) or receive baud tick (1), then check transmit tick in the baud tick case (1)
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (!(which == 0 ? irq === 1'b1 : baud.rxBaudTick === 1'b1) && n < 64);
    `CHK(baud.txBaudTick | (which == 0), 1'b1)
    if (n >= 64)
    begin
      err_count++;
      end_of_test();
    end
  endtask

  // falling edge on the trigger pin, held low long enough to be seen
  task automatic trig;
    @(posedge ref_clk) trigPin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    trigPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  // timer one pulse, then count cycles with both baud ticks high
  task automatic t1pulse(output int h);
    @(posedge ref_clk) tOneOvf <= 1'b1;
    @(posedge ref_clk) tOneOvf <= 1'b0;
    h = 0;
    repeat (4) @(posedge ref_clk) h += (baud.rxBaudTick === 1'b1 && baud.txBaudTick === 1'b1);
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, access kinds, unmapped address
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      xfer(1'b0, rows[i].a, 32'h0, r0, e0);
      `CHK({r0, e0}, {rows[i].e, rows[i].err})
    end
    $display("test register table done");
    // timer mode counts while running and freezes when stopped
    wr(COUNT_OFFSET, 0);
    wr(CTRL_OFFSET, 32'h04);
    wr(CTRL_OFFSET, 32'h00);
    xfer(1'b0, COUNT_OFFSET, 0, r0, e0);
    repeat (10) @(posedge ref_clk);
    xfer(1'b0, COUNT_OFFSET, 0, r1, e0);
    `CHK(r0 != 0, 1'b1)
    `CHK(r1, r0)
    // counter mode: exactly one step per input fall
    wr(COUNT_OFFSET, 0);
    wr(CTRL_OFFSET, 32'h06);
    repeat (3)
    begin
      @(posedge ref_clk) cntPin <= 1'b0;
      repeat (3) @(posedge ref_clk);
      cntPin <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
    wr(CTRL_OFFSET, 32'h00);
    rdchk(COUNT_OFFSET, 32'h3);
    $display("test run modes done");
    // overflow reloads, sets the flag, raises irq; clear drops it
    wr(IRQ_EN_OFFSET, 32'h1);
    wr(RELOAD_OFFSET, 32'hfff0);
    wr(COUNT_OFFSET, 32'hfff8);
    wr(CTRL_OFFSET, 32'h04);
    wait_for(0);
    wr(CTRL_OFFSET, 32'h80);
    rdchk(IRQ_STAT_OFFSET, 32'h1);
    xfer(1'b0, COUNT_OFFSET, 0, r0, e0);
    `CHK(r0[15:4], 12'hfff)
    wr(IRQ_CLR_OFFSET, 32'h1);
    rdchk(CTRL_OFFSET, 32'h00);
    `CHK(irq, 1'b0)
    $display("test overflow done");
    // capture, ignored trigger, trigger reload
    wr(COUNT_OFFSET, 32'h1234);
    wr(CTRL_OFFSET, 32'h09);
    trig();
    rdchk(RELOAD_OFFSET, 32'h1234);
    rdchk(IRQ_STAT_OFFSET, 32'h2);
    wr(IRQ_CLR_OFFSET, 32'h3);
    wr(CTRL_OFFSET, 32'h01);
    wr(COUNT_OFFSET, 32'h4321);
    trig();
    rdchk(RELOAD_OFFSET, 32'h1234);
    rdchk(IRQ_STAT_OFFSET, 32'h0);
    wr(RELOAD_OFFSET, 32'h0abc);
    wr(CTRL_OFFSET, 32'h08);
    trig();
    rdchk(COUNT_OFFSET, 32'h0abc);
    // up/down mode keeps the event flag out of irq
    wr(IRQ_CLR_OFFSET, 32'h3);
    wr(IRQ_EN_OFFSET, 32'h2);
    wr(MODE_OFFSET, 32'h1);
    trig();
    rdchk(IRQ_STAT_OFFSET, 32'h2);
    `CHK(irq, 1'b0)
    wr(MODE_OFFSET, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    wr(IRQ_CLR_OFFSET, 32'h3);
    $display("test trigger done");
    // baud use: trigger ignored, overflow forced to reload, no flag
    wr(COUNT_OFFSET, 32'h5555);
    wr(CTRL_OFFSET, 32'h38);
    trig();
    rdchk(COUNT_OFFSET, 32'h5555);
    rdchk(IRQ_STAT_OFFSET, 32'h0);
    `CHK({baud.rxUseTimer, baud.txUseTimer}, 2'b11)
    t1pulse(hits);
    `CHK(hits, 0)
    wr(RELOAD_OFFSET, 32'hff00);
    wr(COUNT_OFFSET, 32'hfffa);
    wr(CTRL_OFFSET, 32'h3d);
    wait_for(1);
    wr(CTRL_OFFSET, 32'h31);
    xfer(1'b0, COUNT_OFFSET, 0, r0, e0);
    `CHK(r0[15:8], 8'hff)
    rdchk(IRQ_STAT_OFFSET, 32'h0);
    wr(CTRL_OFFSET, 32'h00);
    t1pulse(hits);
    `CHK(hits, 1)
    $display("test baud done");
    // reset in mid-run clears the control register
    wr(CTRL_OFFSET, 32'h0c);
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(CTRL_OFFSET, 32'h00);
    $display("test second reset done");
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
